// *** rtl/fpe_map.vh ***
// Constants for the flash program, erase and power command interpreter
`ifndef FPE_MAP_VH
`define FPE_MAP_VH

// Opcodes with fixed values
`define FPE_OPC_QUAD_PROG  8'h32
`define FPE_OPC_OTP_PROG   8'h42
`define FPE_OPC_OTP_READ   8'h4B
// Opcodes held as replaceable defaults (values arbitrary)
`define FPE_OPC_WRITE_EN   8'hA1
`define FPE_OPC_ERASE_4K   8'hA2
`define FPE_OPC_ERASE_8K   8'hA3
`define FPE_OPC_BLOCK_64K  8'hA4
`define FPE_OPC_BULK       8'hA5
`define FPE_OPC_SLEEP      8'hA6
`define FPE_OPC_WAKE       8'hA7
`define FPE_OPC_CLEAR      8'hA8

// Legacy signature byte (value arbitrary)
`define FPE_SIGNATURE      8'h5A
// 128 KB region holding the 4 KB parameter sectors (address bits 23:17)
`define FPE_PARAM_BLK      7'h00

// Byte counts in a frame: opcode only, opcode plus address, plus one data byte
`define FPE_NB_OPCODE      10'h001
`define FPE_NB_ADDR_END    10'h004
`define FPE_NB_ONE_DATA    10'h005
`define FPE_NB_WAKE_DUMMY  10'h004

// Operation kinds handed to the array back end
`define FPE_OP_PROG        3'h1
`define FPE_OP_OTP_PROG    3'h2
`define FPE_OP_ERASE_4K    3'h3
`define FPE_OP_ERASE_8K    3'h4
`define FPE_OP_BLOCK_64K   3'h5
`define FPE_OP_BULK        3'h6
`define FPE_OP_ABORT       3'h7

// Timing
`define FPE_CLK_MHZ        100
`define FPE_TDP_NS         3000
`define FPE_TRES_NS        3000

`endif

// *** rtl/fpe_fifo.v ***
// Small flop FIFO with a registered output stage
`timescale 1ns/1ps
module fpe_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 4,
	parameter AW    = 2
) (
	input  wire             i_clock,
	input  wire             i_rst_b,
	input  wire             i_in_valid,
	output wire             o_in_ready,
	input  wire [WIDTH-1:0] i_in_data,
	output reg              o_out_valid,
	input  wire             i_out_ready,
	output reg  [WIDTH-1:0] o_out_data,
	output wire             o_idle
);
	localparam [AW:0] FULL = DEPTH[AW:0];

	reg [WIDTH-1:0] mem_q [0:DEPTH-1];
	reg [AW-1:0]    wp_q;
	reg [AW-1:0]    rp_q;
	reg [AW:0]      cnt_q;
	wire            push;
	wire            pop;

	// Pop refills the output stage when it is empty or being taken
	assign o_in_ready = (cnt_q != FULL);
	assign push       = i_in_valid & o_in_ready;
	assign pop        = (cnt_q != {(AW+1){1'b0}}) & (~o_out_valid | i_out_ready);
	assign o_idle     = (cnt_q == {(AW+1){1'b0}}) & ~o_out_valid;

	// Storage needs no reset; pointers guard it
	always @(posedge i_clock) begin
		if (push) begin
			mem_q[wp_q] <= i_in_data;
		end
	end

	// Pointers, count and output stage; DEPTH must be a power of two
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			wp_q        <= {AW{1'b0}};
			rp_q        <= {AW{1'b0}};
			cnt_q       <= {(AW+1){1'b0}};
			o_out_valid <= 1'b0;
			o_out_data  <= {WIDTH{1'b0}};
		end else begin
			if (push) begin
				wp_q <= wp_q + 1'b1;
			end
			if (push & ~pop) begin
				cnt_q <= cnt_q + 1'b1;
			end else if (pop & ~push) begin
				cnt_q <= cnt_q - 1'b1;
			end
			if (pop) begin
				o_out_data  <= mem_q[rp_q];
				o_out_valid <= 1'b1;
				rp_q        <= rp_q + 1'b1;
			end else if (i_out_ready) begin
				o_out_valid <= 1'b0;
			end
		end
	end
endmodule // fpe_fifo

// *** rtl/fpe_cmd_core.v ***
// Serial flash command interpreter for program, erase, power and one-time area commands
//
// Behaviour
// - Quad page program is taken only while the quad enable input is 1.
// - Quad program: opcode 32h, 24-bit address, data on four lanes, up to 256 bytes.
// - Quad program needs the write enable latch set; chip select stays low throughout.
// - 4K/8K erase needs opcode plus exactly three address bytes; starts at chip select rise.
// - Self-timed operations hold write-in-progress high and clear the write enable latch.
// - Parameter erase of a protected sector is not executed.
// - 8K erase ignores the lowest sector bit and wipes sectors n and n+1.
// - Sectors of the pair that are not parameter sectors are left alone.
// - 64K erase needs opcode plus exactly three address bytes, any address inside.
// - 64K and bulk erase run only when all block protect bits are 0.
// - Bulk erase is one opcode byte, needs write enable, wipes the whole array.
// - Deep sleep is one opcode byte; the low-power state follows the sleep delay.
// - In deep sleep every command except wake is ignored.
// - Deep sleep command arriving during a busy operation is rejected.
// - Wake returns to standby after the release delay; write enable latch unchanged.
// - Wake opcode plus three dummy bytes, then 8-bit signature out on falling edges.
// - The signature repeats while chip select stays low.
// - Wake works without prior sleep; ignored while an operation runs.
// - Clear command resets both fail flags and the interpreter, keeps the latch.
// - One-time program carries exactly one data byte and needs write enable.
// - One-time programming only clears bits; data ones leave stored bits alone.
// - One-time read behaves as fast read; the 24-bit read address wraps to 0 past the top address.
// - Page data wraps within the page; last 256 bytes programmed.
// - Programming starts only when chip select rises on a byte boundary.
`timescale 1ns/1ps
`include "fpe_map.vh"
module fpe_cmd_core #(
	parameter [7:0] OPC_WRITE_EN  = `FPE_OPC_WRITE_EN,
	parameter [7:0] OPC_ERASE_4K  = `FPE_OPC_ERASE_4K,
	parameter [7:0] OPC_ERASE_8K  = `FPE_OPC_ERASE_8K,
	parameter [7:0] OPC_BLOCK_64K = `FPE_OPC_BLOCK_64K,
	parameter [7:0] OPC_BULK      = `FPE_OPC_BULK,
	parameter [7:0] OPC_SLEEP     = `FPE_OPC_SLEEP,
	parameter [7:0] OPC_WAKE      = `FPE_OPC_WAKE,
	parameter [7:0] OPC_CLEAR     = `FPE_OPC_CLEAR,
	parameter [7:0] SIGNATURE     = `FPE_SIGNATURE,
	parameter [6:0] PARAM_BLK     = `FPE_PARAM_BLK
) (
	input  wire        i_clock,
	input  wire        i_rst_b,
	input  wire        i_cs_b,
	input  wire        i_sck,
	input  wire [3:0]  i_io,
	output reg  [3:0]  o_io,
	output reg  [3:0]  o_io_oe,
	input  wire        i_quad_en,
	input  wire [2:0]  i_block_protect,
	input  wire        i_reg_write_busy,
	output reg         o_write_enable_latch,
	output reg         o_write_in_progress,
	output reg         o_deep_sleep,
	output reg         o_erase_fail_flag,
	output reg         o_program_fail_flag,
	output reg         o_op_start,
	output reg  [2:0]  o_op_kind,
	output reg  [23:0] o_op_addr,
	output reg  [1:0]  o_op_pair,
	input  wire        i_op_done,
	input  wire        i_op_fail,
	output wire        o_wr_valid,
	output wire [7:0]  o_wr_data,
	output wire [7:0]  o_wr_offset,
	input  wire        i_wr_ready,
	output reg         o_rd_req,
	output reg  [23:0] o_rd_addr,
	input  wire [7:0]  i_rd_data
);
	localparam [5:0] ST_IDLE  = 6'b00_0001;
	localparam [5:0] ST_CMD   = 6'b00_0010;
	localparam [5:0] ST_ADDR  = 6'b00_0100;
	localparam [5:0] ST_DUMMY = 6'b00_1000;
	localparam [5:0] ST_DATA  = 6'b01_0000;
	localparam [5:0] ST_OUT   = 6'b10_0000;

	localparam integer TDP_CYC  = (`FPE_TDP_NS * `FPE_CLK_MHZ + 999) / 1000;
	localparam integer TRES_CYC = (`FPE_TRES_NS * `FPE_CLK_MHZ + 999) / 1000;
	localparam [11:0]  TDP_LD   = TDP_CYC[11:0];
	localparam [11:0]  TRES_LD  = TRES_CYC[11:0];

	// Block protect covers the top 2^(bp-1) of 64 sectors; bp of 7 covers all
	function prot;
		input [23:0] a;
		input [2:0]  bp;
		reg   [6:0]  lim;
		begin
			lim  = 7'h40 - (7'h01 << (bp - 3'h1));
			prot = (bp != 3'h0) && ({1'b0, a[21:16]} >= lim);
		end
	endfunction

	// A 4 KB sector is a parameter sector only inside the parameter region
	function valid4k;
		input [23:0] a;
		begin
			valid4k = (a[23:17] == PARAM_BLK);
		end
	endfunction

	reg         rst_s1;
	reg         rst_n;
	reg  [5:0]  in_s1;
	reg  [5:0]  in_s2;
	reg         sck_p;
	reg         cs_p;
	reg  [5:0]  st_q;
	reg  [7:0]  opc_q;
	reg  [7:0]  sh_q;
	reg  [2:0]  bit_q;
	reg  [9:0]  nb_q;
	reg  [23:0] addr_q;
	reg  [7:0]  dcnt_q;
	reg         quad_q;
	reg         acc_q;
	reg  [7:0]  osh_q;
	reg  [2:0]  ocnt_q;
	reg         oact_q;
	reg         push_q;
	reg  [15:0] push_w_q;
	reg         pend_q;
	reg  [2:0]  pkind_q;
	reg  [1:0]  ppair_q;
	reg  [11:0] tmr_q;
	reg  [1:0]  tmode_q;
	wire        cs_s;
	wire        sck_s;
	wire [3:0]  io_s;
	wire        cs_rise;
	wire        cs_fall;
	wire        sck_rise;
	wire        sck_fall;
	wire [7:0]  sh_n;
	wire [2:0]  bit_n;
	wire        byte_done;
	wire        busy;
	wire        sleep_gate;
	wire        clean;
	wire        ok1;
	wire        ok4;
	wire        bp_zero;
	wire [23:0] n8k;
	wire [23:0] n8k1;
	wire [1:0]  pair8k;
	wire        prot8k;
	wire        fifo_ready;
	wire        fifo_idle;
	wire [15:0] fifo_out;

	// Reset release through two flops
	always @(posedge i_clock or negedge i_rst_b) begin
		if (!i_rst_b) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Pins pass two flops; the third stage only feeds edge detection
	always @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			in_s1 <= 6'h20;
			in_s2 <= 6'h20;
			sck_p <= 1'b0;
			cs_p  <= 1'b1;
		end else begin
			in_s1 <= {i_cs_b, i_sck, i_io};
			in_s2 <= in_s1;
			sck_p <= in_s2[4];
			cs_p  <= in_s2[5];
		end
	end

	assign cs_s     = in_s2[5];
	assign sck_s    = in_s2[4];
	assign io_s     = in_s2[3:0];
	assign cs_rise  = cs_s & ~cs_p;
	assign cs_fall  = ~cs_s & cs_p;
	assign sck_rise = ~cs_s & sck_s & ~sck_p;
	assign sck_fall = ~cs_s & ~sck_s & sck_p;

	// Quad mode takes four bits a rising edge, IO3 first
	assign sh_n      = quad_q ? {sh_q[3:0], io_s} : {sh_q[6:0], io_s[0]};
	assign bit_n     = bit_q + (quad_q ? 3'h4 : 3'h1);
	assign byte_done = sck_rise & (bit_n == 3'h0);

	// Frame-end qualifiers
	assign busy       = o_write_in_progress | i_reg_write_busy | pend_q;
	assign sleep_gate = ~o_deep_sleep | (opc_q == OPC_WAKE);
	assign clean      = (bit_q == 3'h0) & sleep_gate;
	assign ok1        = clean & (nb_q == `FPE_NB_OPCODE);
	assign ok4        = clean & (nb_q == `FPE_NB_ADDR_END);
	assign bp_zero    = (i_block_protect == 3'h0);
	assign n8k        = {addr_q[23:13], 13'h0000};
	assign n8k1       = {addr_q[23:13], 1'b1, 12'h000};
	assign pair8k     = {valid4k(n8k1), valid4k(n8k)};
	assign prot8k     = prot(n8k, i_block_protect) | prot(n8k1, i_block_protect);

	// Serial frame: byte assembly, decode on each byte, output on falling edges
	always @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			st_q      <= ST_IDLE;
			opc_q     <= 8'h00;
			sh_q      <= 8'h00;
			bit_q     <= 3'h0;
			nb_q      <= 10'h000;
			addr_q    <= 24'h00_0000;
			dcnt_q    <= 8'h00;
			quad_q    <= 1'b0;
			acc_q     <= 1'b0;
			osh_q     <= 8'h00;
			ocnt_q    <= 3'h0;
			oact_q    <= 1'b0;
			o_io      <= 4'h0;
			o_io_oe   <= 4'h0;
			o_rd_req  <= 1'b0;
			o_rd_addr <= 24'h00_0000;
		end else begin
			o_rd_req <= 1'b0;
			if (cs_fall) begin
				st_q   <= ST_CMD;
				sh_q   <= 8'h00;
				bit_q  <= 3'h0;
				nb_q   <= 10'h000;
				dcnt_q <= 8'h00;
				quad_q <= 1'b0;
				acc_q  <= 1'b0;
				oact_q <= 1'b0;
				ocnt_q <= 3'h0;
			end else if (cs_s) begin
				st_q    <= ST_IDLE;
				oact_q  <= 1'b0;
				o_io_oe <= 4'h0;
			end
			if (sck_rise) begin
				sh_q  <= sh_n;
				bit_q <= bit_n;
			end
			if (byte_done) begin
				if (nb_q != 10'h3FF) begin
					nb_q <= nb_q + 10'h001;
				end
				case (st_q)
				ST_CMD: begin
					opc_q <= sh_n;
					if (o_deep_sleep && sh_n != OPC_WAKE) begin
						st_q <= ST_IDLE;
					end else if (sh_n == OPC_WAKE) begin
						st_q <= ST_DUMMY;
					end else if (sh_n == `FPE_OPC_QUAD_PROG) begin
						st_q   <= i_quad_en ? ST_ADDR : ST_IDLE;
						quad_q <= i_quad_en;
					end else if (sh_n == OPC_ERASE_4K || sh_n == OPC_ERASE_8K ||
							sh_n == OPC_BLOCK_64K || sh_n == `FPE_OPC_OTP_PROG ||
							sh_n == `FPE_OPC_OTP_READ) begin
						st_q <= ST_ADDR;
					end else begin
						st_q <= ST_IDLE;
					end
				end
				ST_ADDR: begin
					addr_q <= {addr_q[15:0], sh_n};
					if (nb_q == `FPE_NB_ADDR_END - 10'h001) begin
						if (opc_q == `FPE_OPC_OTP_READ) begin
							st_q      <= busy ? ST_IDLE : ST_DUMMY;
							o_rd_req  <= ~busy;
							o_rd_addr <= {addr_q[15:0], sh_n};
						end else if (opc_q == OPC_ERASE_4K || opc_q == OPC_ERASE_8K ||
								opc_q == OPC_BLOCK_64K) begin
							st_q <= ST_IDLE;
						end else begin
							// Data flows to the page latch only for an acceptable program
							st_q  <= ST_DATA;
							acc_q <= o_write_enable_latch & ~busy &
								((opc_q == `FPE_OPC_OTP_PROG) |
								~prot({addr_q[15:0], sh_n}, i_block_protect));
						end
					end
				end
				ST_DUMMY: begin
					if (opc_q == OPC_WAKE && nb_q == `FPE_NB_WAKE_DUMMY - 10'h001) begin
						st_q   <= busy ? ST_IDLE : ST_OUT;
						oact_q <= ~busy;
						osh_q  <= SIGNATURE;
					end else if (opc_q == `FPE_OPC_OTP_READ) begin
						// One dummy byte, as in fast read
						st_q      <= ST_OUT;
						oact_q    <= 1'b1;
						osh_q     <= i_rd_data;
						o_rd_req  <= 1'b1;
						o_rd_addr <= o_rd_addr + 24'h00_0001;
					end
				end
				ST_DATA: begin
					dcnt_q <= dcnt_q + 8'h01;
				end
				default: begin
					st_q <= st_q;
				end
				endcase
			end
			// Output shifts on falling edges, single lane on IO1
			if (sck_fall && oact_q) begin
				o_io[1]    <= osh_q[7];
				o_io_oe[1] <= 1'b1;
				ocnt_q     <= ocnt_q + 3'h1;
				if (ocnt_q == 3'h7) begin
					if (opc_q == OPC_WAKE) begin
						osh_q <= SIGNATURE;
					end else begin
						osh_q     <= i_rd_data;
						o_rd_req  <= 1'b1;
						o_rd_addr <= o_rd_addr + 24'h00_0001;
					end
				end else begin
					osh_q <= {osh_q[6:0], 1'b0};
				end
			end
		end
	end

	// Data bytes wait one slot for the FIFO; a byte landing on a full slot is an overrun
	always @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			push_q   <= 1'b0;
			push_w_q <= 16'h0000;
		end else begin
			if (push_q && fifo_ready) begin
				push_q <= 1'b0;
			end
			if (byte_done && st_q == ST_DATA && acc_q) begin
				push_q   <= 1'b1;
				// Offset wraps in the page so the last 256 bytes win; one-time
				// data goes as sent since the array only ever clears bits
				push_w_q <= {addr_q[7:0] + dcnt_q, sh_n};
			end
		end
	end

	// Page latch writes cross a small FIFO; the back end may stall it
	fpe_fifo #(
		.WIDTH (16),
		.DEPTH (4),
		.AW    (2)
	) u_fifo (
		.i_clock     (i_clock),
		.i_rst_b     (rst_n),
		.i_in_valid  (push_q),
		.o_in_ready  (fifo_ready),
		.i_in_data   (push_w_q),
		.o_out_valid (o_wr_valid),
		.i_out_ready (i_wr_ready),
		.o_out_data  (fifo_out),
		.o_idle      (fifo_idle)
	);

	assign o_wr_offset = fifo_out[15:8];
	assign o_wr_data   = fifo_out[7:0];

	// Frame-end commands, operation launch, status and power state
	always @(posedge i_clock or negedge rst_n) begin
		if (!rst_n) begin
			o_write_enable_latch <= 1'b0;
			o_write_in_progress  <= 1'b0;
			o_deep_sleep         <= 1'b0;
			o_erase_fail_flag    <= 1'b0;
			o_program_fail_flag  <= 1'b0;
			o_op_start           <= 1'b0;
			o_op_kind            <= 3'h0;
			o_op_addr            <= 24'h00_0000;
			o_op_pair            <= 2'h0;
			pend_q               <= 1'b0;
			pkind_q              <= 3'h0;
			ppair_q              <= 2'h0;
			tmr_q                <= 12'h000;
			tmode_q              <= 2'h0;
		end else begin
			o_op_start <= 1'b0;
			if (cs_rise && nb_q != 10'h000) begin
				case (opc_q)
				OPC_WRITE_EN: begin
					if (ok1 && !o_deep_sleep) begin
						o_write_enable_latch <= 1'b1;
					end
				end
				OPC_CLEAR: begin
					if (ok1 && !o_deep_sleep) begin
						// Latch untouched; pending launch dropped with the interpreter
						o_erase_fail_flag   <= 1'b0;
						o_program_fail_flag <= 1'b0;
						pend_q              <= 1'b0;
					end
				end
				OPC_BULK: begin
					if (ok1 && o_write_enable_latch && bp_zero && !busy) begin
						pend_q  <= 1'b1;
						pkind_q <= `FPE_OP_BULK;
					end
				end
				OPC_BLOCK_64K: begin
					if (ok4 && o_write_enable_latch && bp_zero && !busy) begin
						pend_q  <= 1'b1;
						pkind_q <= `FPE_OP_BLOCK_64K;
					end
				end
				OPC_ERASE_4K: begin
					if (ok4 && o_write_enable_latch && !busy && valid4k(addr_q) &&
							!prot(addr_q, i_block_protect)) begin
						pend_q  <= 1'b1;
						pkind_q <= `FPE_OP_ERASE_4K;
					end
				end
				OPC_ERASE_8K: begin
					if (ok4 && o_write_enable_latch && !busy && pair8k != 2'h0 &&
							!prot8k) begin
						pend_q  <= 1'b1;
						pkind_q <= `FPE_OP_ERASE_8K;
						ppair_q <= pair8k;
					end
				end
				`FPE_OPC_QUAD_PROG, `FPE_OPC_OTP_PROG: begin
					if (acc_q) begin
						pend_q <= 1'b1;
						if (!clean || nb_q < `FPE_NB_ONE_DATA) begin
							pkind_q <= `FPE_OP_ABORT;
						end else if (opc_q == `FPE_OPC_QUAD_PROG) begin
							pkind_q <= `FPE_OP_PROG;
						end else if (nb_q == `FPE_NB_ONE_DATA) begin
							pkind_q <= `FPE_OP_OTP_PROG;
						end else begin
							pkind_q <= `FPE_OP_ABORT;
						end
					end
				end
				OPC_SLEEP: begin
					if (ok1 && !busy && !o_deep_sleep && tmode_q == 2'h0) begin
						tmr_q   <= TDP_LD;
						tmode_q <= 2'h1;
					end
				end
				OPC_WAKE: begin
					if (clean && !busy && o_deep_sleep) begin
						tmr_q   <= TRES_LD;
						tmode_q <= 2'h2;
					end
				end
				default: begin
					pend_q <= pend_q;
				end
				endcase
			end
			// Launch waits until every latched byte has reached the back end
			if (pend_q && fifo_idle && !push_q) begin
				pend_q     <= 1'b0;
				o_op_start <= 1'b1;
				o_op_kind  <= pkind_q;
				o_op_addr  <= (pkind_q == `FPE_OP_ERASE_8K) ? n8k : addr_q;
				o_op_pair  <= ppair_q;
				if (pkind_q != `FPE_OP_ABORT) begin
					o_write_in_progress  <= 1'b1;
					o_write_enable_latch <= 1'b0;
				end
			end
			if (i_op_done && o_write_in_progress) begin
				o_write_in_progress <= 1'b0;
			end
			// Failure sets win over a clear in the same cycle
			if (i_op_done && i_op_fail && o_write_in_progress) begin
				if (o_op_kind == `FPE_OP_PROG || o_op_kind == `FPE_OP_OTP_PROG) begin
					o_program_fail_flag <= 1'b1;
				end else begin
					o_erase_fail_flag <= 1'b1;
				end
			end
			if (push_q && !fifo_ready && byte_done && st_q == ST_DATA && acc_q) begin
				o_program_fail_flag <= 1'b1;
			end
			// Power-state delays count down after the frame ends
			if (tmode_q != 2'h0) begin
				tmr_q <= tmr_q - 12'h001;
				if (tmr_q == 12'h001) begin
					tmode_q      <= 2'h0;
					o_deep_sleep <= (tmode_q == 2'h1);
				end
			end
		end
	end
endmodule // fpe_cmd_core

// *** verification/fpe_chk.sv ***
// Port checker for the flash command interpreter
`timescale 1ns/1ps
`include "fpe_map.vh"
module fpe_chk (
	input wire       i_clock,
	input wire       i_rst_b,
	input wire       i_cs_b,
	input wire       i_quad_en,
	input wire [2:0] i_block_protect,
	input wire       i_op_done,
	input wire       o_write_enable_latch,
	input wire       o_write_in_progress,
	input wire       o_deep_sleep,
	input wire       o_op_start,
	input wire [2:0] o_op_kind,
	input wire [3:0] o_io_oe
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// A real launch, an abort only discards the page latch
	wire run_op = o_op_start && (o_op_kind != `FPE_OP_ABORT);

	property p_busy_set; run_op |-> ##[0:1] o_write_in_progress; endproperty
	a_busy_set: assert property (p_busy_set) else $error("busy not raised at launch");
	property p_latch_clr; run_op |-> ##[0:1] !o_write_enable_latch; endproperty
	a_latch_clr: assert property (p_latch_clr) else $error("latch kept at launch");
	property p_busy_end; i_op_done && o_write_in_progress |=> !o_write_in_progress; endproperty
	a_busy_end: assert property (p_busy_end) else $error("busy kept after done");
	property p_need_latch; run_op |-> $past(o_write_enable_latch); endproperty
	a_need_latch: assert property (p_need_latch) else $error("launch without latch");
	property p_cs_high; o_op_start |-> i_cs_b && $past(i_cs_b, 2); endproperty
	a_cs_high: assert property (p_cs_high) else $error("launch inside a frame");
	property p_protect; o_op_start && o_op_kind inside {`FPE_OP_BLOCK_64K, `FPE_OP_BULK}
		|-> i_block_protect == 3'h0; endproperty
	a_protect: assert property (p_protect) else $error("erase of protected array");
	property p_quad; o_op_start && o_op_kind == `FPE_OP_PROG |-> i_quad_en; endproperty
	a_quad: assert property (p_quad) else $error("quad program while disabled");
	property p_quiet; o_deep_sleep |-> !o_op_start; endproperty
	a_quiet: assert property (p_quiet) else $error("launch in deep sleep");
	property p_sleep_idle; $rose(o_deep_sleep) |-> !o_write_in_progress; endproperty
	a_sleep_idle: assert property (p_sleep_idle) else $error("sleep while busy");

	c_bulk: cover property (o_op_start && o_op_kind == `FPE_OP_BULK);
	c_sleep: cover property ($rose(o_deep_sleep));
	c_shift: cover property (o_io_oe[1]);
endmodule // fpe_chk

bind fpe_cmd_core fpe_chk u_chk (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_cs_b(i_cs_b),
	.i_quad_en(i_quad_en), .i_block_protect(i_block_protect), .i_op_done(i_op_done),
	.o_write_enable_latch(o_write_enable_latch), .o_write_in_progress(o_write_in_progress),
	.o_deep_sleep(o_deep_sleep), .o_op_start(o_op_start), .o_op_kind(o_op_kind),
	.o_io_oe(o_io_oe));

// *** verification/fpe_host.sv ***
// Host controller model driving the serial flash pins in mode 0
`timescale 1ns/1ps
module fpe_host (
	input  wire       i_so,
	output reg        o_cs_b,
	output reg        o_sck,
	output reg  [3:0] o_io
);
	localparam real HALF = 62.5;

	initial begin
		o_cs_b = 1'b1;
		o_sck  = 1'b0;
		o_io   = 4'h0;
	end
	// Clock idles low, so a frame starts with data set up before the first rise
	task open;
		begin
			o_cs_b = 1'b0;
			#HALF;
		end
	endtask
	// Select rises on a byte boundary after the last fall; lines drift
	task close;
		begin
			#HALF;
			o_cs_b = 1'b1;
			o_io   = ~o_io;
			#100;
		end
	endtask
	// Single lane byte, MSB first on IO0
	task tx(input [7:0] b);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				o_io[0] = b[i];
				#HALF o_sck = 1'b1;
				#HALF o_sck = 1'b0;
			end
		end
	endtask
	// Four lane byte, upper nibble first with IO3 the top bit
	task tx4(input [7:0] b);
		begin
			o_io = b[7:4];
			#HALF o_sck = 1'b1;
			#HALF o_sck = 1'b0;
			o_io = b[3:0];
			#HALF o_sck = 1'b1;
			#HALF o_sck = 1'b0;
		end
	endtask
	// Output bits are taken at the rise, half a period after the device shifts
	task rx(output [7:0] b);
		integer i;
		begin
			for (i = 7; i >= 0; i = i - 1) begin
				#HALF o_sck = 1'b1;
				b[i] = i_so;
				#HALF o_sck = 1'b0;
			end
		end
	endtask
endmodule // fpe_host

// *** verification/tb_top.sv ***
// Testbench for the flash command interpreter
`timescale 1ns/1ps
`include "fpe_map.vh"
module tb_top;
	reg         i_clock, i_rst_b, i_quad_en, i_op_done, i_op_fail, rwb;
	reg  [2:0]  i_block_protect;
	wire        cs_b, sck, wen_l, busy, sleep, efail, pfail, start, wr_valid;
	wire [3:0]  host_io, io_w, o_io, o_io_oe;
	wire [2:0]  kind;
	wire [23:0] op_addr, rd_addr;
	wire [1:0]  pair;
	wire [7:0]  wr_data, wr_off;
	integer     n_mismatch, check_count, n_start, n0;
	reg  [2:0]  kind_q;
	reg  [23:0] addr_q;
	reg  [1:0]  pair_q;
	reg  [15:0] wd_q;
	reg  [7:0]  rb;

	always #5 i_clock = ~i_clock;
	// Device drives a line only while its enable is high
	assign io_w = (o_io & o_io_oe) | (host_io & ~o_io_oe);

	fpe_host host (.i_so(io_w[1]), .o_cs_b(cs_b), .o_sck(sck), .o_io(host_io));
	fpe_cmd_core dut (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_cs_b(cs_b), .i_sck(sck),
		.i_io(io_w), .o_io(o_io), .o_io_oe(o_io_oe), .i_quad_en(i_quad_en),
		.i_block_protect(i_block_protect), .i_reg_write_busy(rwb),
		.o_write_enable_latch(wen_l), .o_write_in_progress(busy), .o_deep_sleep(sleep),
		.o_erase_fail_flag(efail), .o_program_fail_flag(pfail), .o_op_start(start),
		.o_op_kind(kind), .o_op_addr(op_addr), .o_op_pair(pair), .i_op_done(i_op_done),
		.i_op_fail(i_op_fail), .o_wr_valid(wr_valid), .o_wr_data(wr_data),
		.o_wr_offset(wr_off), .i_wr_ready(1'b1), .o_rd_req(), .o_rd_addr(rd_addr),
		.i_rd_data(rd_addr[7:0]));

	// Launch recorder; the page latch never stalls here
	always @(posedge i_clock) begin
		if (start) begin
			n_start <= n_start + 1;
			kind_q  <= kind;
			addr_q  <= op_addr;
			pair_q  <= pair;
		end
		if (wr_valid)
			wd_q <= {wr_off, wr_data};
	end

	task chk(input [8*6:1] nm, input [23:0] exp, input [23:0] got);
		begin
			check_count = check_count + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("BAD %0s expected %h seen %h", nm, exp, got);
			end
		end
	endtask
	task clk_n(input integer n);
		begin
			repeat (n) @(posedge i_clock);
			#1;
		end
	endtask
	task frame;
		begin
			n0 = n_start;
			host.open;
		end
	endtask
	task cmd1(input [7:0] op);
		begin
			frame;
			host.tx(op);
			host.close;
			clk_n(4);
		end
	endtask
	task addr3(input [23:0] a);
		begin
			host.tx(a[23:16]);
			host.tx(a[15:8]);
			host.tx(a[7:0]);
		end
	endtask
	// Bounded wait; running out fails and ends the run
	task wait_start;
		integer i;
		begin
			for (i = 0; i < 50 && n_start == n0; i = i + 1)
				clk_n(1);
			chk("launch", 24'h1, n_start != n0);
			if (n_start == n0)
				complete_run;
		end
	endtask
	task finish(input f);
		begin
			i_op_done = 1'b1;
			i_op_fail = f;
			clk_n(1);
			i_op_done = 1'b0;
			i_op_fail = 1'b0;
			clk_n(2);
		end
	endtask
	task complete_run;
		begin
			$display("Checks %0d mismatches %0d", check_count, n_mismatch);
			if (n_mismatch == 0 && check_count > 0)
				$display("Simulation passed");
			else
				$display("Simulation failed");
			$finish;
		end
	endtask

	initial begin
		{i_clock, i_rst_b, i_quad_en, i_op_done, i_op_fail, rwb} = 6'h00;
		{n_mismatch, check_count, n_start, n0} = 0;
		i_block_protect = 3'h1;
		repeat (10) @(posedge i_clock);
		#1 i_rst_b = 1'b1;
		clk_n(5);
		chk("busy", 24'h0, busy);
		// Protected array refuses bulk erase; unprotected array refuses 64K erase with a stray byte
		cmd1(`FPE_OPC_WRITE_EN);
		cmd1(`FPE_OPC_BULK);
		clk_n(20);
		chk("busy", 24'h0, busy);
		chk("wen", 24'h1, wen_l);
		i_block_protect = 3'h0;
		frame;
		host.tx(`FPE_OPC_BLOCK_64K);
		addr3(24'h01_0000);
		host.tx(8'h00);
		host.close;
		clk_n(20);
		chk("busy", 24'h0, busy);
		// 8K erase pairs sector 2 with 3; sleep while busy is refused
		frame;
		host.tx(`FPE_OPC_ERASE_8K);
		addr3(24'h00_3123);
		host.close;
		wait_start;
		chk("kind", `FPE_OP_ERASE_8K, kind_q);
		chk("addr", 24'h00_2000, addr_q & 24'hFF_F000);
		chk("pair", 24'h3, pair_q);
		chk("busy", 24'h1, busy);
		chk("wen", 24'h0, wen_l);
		cmd1(`FPE_OPC_SLEEP);
		clk_n(320);
		chk("sleep", 24'h0, sleep);
		finish(1'b1);
		chk("busy", 24'h0, busy);
		chk("efail", 24'h1, efail);
		// Clear drops the flags but not the latch
		cmd1(`FPE_OPC_WRITE_EN);
		cmd1(`FPE_OPC_CLEAR);
		chk("efail", 24'h0, efail);
		chk("pfail", 24'h0, pfail);
		chk("wen", 24'h1, wen_l);
		cmd1(`FPE_OPC_BULK);
		wait_start;
		chk("kind", `FPE_OP_BULK, kind_q);
		clk_n(5);
		finish(1'b0);
		rwb = 1'b1;
		cmd1(`FPE_OPC_SLEEP);
		rwb = 1'b0;
		clk_n(310);
		chk("sleep", 24'h0, sleep);
		// Deep sleep ignores erase; wake reads the signature twice, latch survives
		cmd1(`FPE_OPC_WRITE_EN);
		cmd1(`FPE_OPC_SLEEP);
		clk_n(310);
		chk("sleep", 24'h1, sleep);
		cmd1(`FPE_OPC_BULK);
		clk_n(20);
		chk("busy", 24'h0, busy);
		frame;
		host.tx(`FPE_OPC_WAKE);
		addr3(24'h00_0000);
		host.rx(rb);
		chk("sig", `FPE_SIGNATURE, rb);
		host.rx(rb);
		chk("sig", `FPE_SIGNATURE, rb);
		host.close;
		clk_n(310);
		chk("sleep", 24'h0, sleep);
		chk("wen", 24'h1, wen_l);
		// One-time program: two data bytes refused, one byte taken
		frame;
		host.tx(`FPE_OPC_OTP_PROG);
		addr3(24'h00_0110);
		host.tx(8'hA5);
		host.tx(8'h0F);
		host.close;
		clk_n(20);
		chk("busy", 24'h0, busy);
		frame;
		host.tx(`FPE_OPC_ERASE_4K);
		addr3(24'h00_1000);
		host.close;
		wait_start;
		chk("kind", `FPE_OP_ERASE_4K, kind_q);
		finish(1'b0);
		cmd1(`FPE_OPC_WRITE_EN);
		frame;
		host.tx(`FPE_OPC_OTP_PROG);
		addr3(24'h00_0110);
		host.tx(8'hA5);
		host.close;
		wait_start;
		chk("kind", `FPE_OP_OTP_PROG, kind_q);
		chk("wdata", 24'h10A5, wd_q);
		finish(1'b0);
		frame;
		host.tx(`FPE_OPC_OTP_READ);
		addr3(24'h00_0120);
		host.tx(8'h00);
		host.rx(rb);
		chk("otprd", 24'h20, rb);
		host.rx(rb);
		chk("otprd", 24'h21, rb);
		host.close;
		// Quad program refused while disabled, then taken on four lanes
		repeat (2) begin
			cmd1(`FPE_OPC_WRITE_EN);
			frame;
			host.tx(`FPE_OPC_QUAD_PROG);
			host.tx4(8'h00);
			host.tx4(8'h01);
			host.tx4(8'hF0);
			host.tx4(i_quad_en ? 8'hC3 : 8'h3C);
			host.close;
			if (i_quad_en) begin
				wait_start;
				chk("kind", `FPE_OP_PROG, kind_q);
				chk("wdata", 24'hF0C3, wd_q);
				finish(1'b0);
			end else begin
				clk_n(20);
				chk("busy", 24'h0, busy);
			end
			i_quad_en = 1'b1;
		end
		complete_run;
	end
endmodule // tb_top
